//--- tcat_acq.v
// Burst sequencing, drift tracking and detection for two touch channels.
// Assumes comparator pins that rise when a channel's measurement completes.
//
// Implementation choices: the register offsets and the Avalon-MM register port.
`timescale 1ns/1ns
`include "tcat_defines.vh"

module tcat_acq #(
    parameter BASE_INTERVAL_CYC = `TCAT_BASE_INTERVAL_CYC,
    parameter XFER_DIV          = `TCAT_XFER_DIV,
    parameter [15:0] MAX_XFER   = 16'hFFFF
) (
    // Clock and reset.
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Avalon-MM register slave.
    input  wire [2:0]  avs_address_i,
    input  wire        avs_read_i,
    input  wire        avs_write_i,
    input  wire [31:0] avs_writedata_i,
    output reg  [31:0] avs_readdata_o,
    output reg         avs_waitrequest_o,
    // Sense channel pins.
    input  wire        cmp_a_i,
    input  wire        cmp_b_i,
    output reg         xfer_a_o,
    output reg         xfer_b_o,
    // Detect outputs.
    output reg         detect_a_o,
    output reg         detect_b_o
);

    localparam [1:0] ST_BURST_B = 2'h0;
    localparam [1:0] ST_BURST_A = 2'h1;
    localparam [1:0] ST_EVAL    = 2'h2;
    localparam [1:0] ST_SLEEP   = 2'h3;

    function [15:0] dev_f;
        input [15:0] ref_v;
        input [15:0] sig_v;
        begin
            if (sig_v < ref_v) begin
                dev_f = ref_v - sig_v;
            end else begin
                dev_f = 16'h0000;
            end
        end
    endfunction

    // Release count target is the confirm target capped at six.
    function [2:0] rel_tgt_f;
        input [7:0] tgt_v;
        reg   [7:0] lim_v;
        begin
            if (tgt_v > `TCAT_REL_TGT_M1_MAX) begin
                lim_v = `TCAT_REL_TGT_M1_MAX;
            end else begin
                lim_v = tgt_v;
            end
            rel_tgt_f = lim_v[2:0];
        end
    endfunction

    reg  [7:0]  sleep_r;
    reg  [7:0]  rise_r;
    reg  [7:0]  fall_r;
    reg         fast_sel_r;
    reg  [7:0]  maxon_r;
    reg  [4:0]  thr_r      [0:1];
    reg  [4:0]  hys_r      [0:1];
    reg  [7:0]  tgt_r      [0:1];
    reg  [15:0] sig_r      [0:1];
    reg  [15:0] ref_r      [0:1];
    reg  [7:0]  conf_r     [0:1];
    reg  [2:0]  rel_r      [0:1];
    reg  [7:0]  mo_r       [0:1];
    reg  [7:0]  mo_pre_r   [0:1];
    reg         det_r      [0:1];
    reg         cal_r      [0:1];
    reg  [1:0]  state_r;
    reg  [31:0] cyc_r;
    reg  [7:0]  ti_num_r;
    reg  [15:0] xdiv_r;
    reg  [15:0] xcnt_r;
    reg  [7:0]  pre_r;
    reg  [7:0]  rise_cnt_r;
    reg  [7:0]  fall_cnt_r;
    reg  [1:0]  cmp_a_s_r;
    reg  [1:0]  cmp_b_s_r;
    reg  [31:0] rd_nxt;
    reg         fast_now;
    integer     i;
    integer     j;

    wire        wr_en    = avs_write_i & ~avs_waitrequest_o;
    wire        xfer_en  = (xdiv_r == XFER_DIV[15:0] - 16'h0001);
    wire        cmp_cur  = (state_r == ST_BURST_B) ? cmp_b_s_r[1] : cmp_a_s_r[1];
    wire        burst_end = (xcnt_r != 16'h0000) & (cmp_cur | (xcnt_r == MAX_XFER));
    wire        slept    = (sleep_r != 8'h00);
    wire        drift_unit = slept | (pre_r[3:0] == 4'hF);
    wire        ti_end   = (cyc_r == BASE_INTERVAL_CYC - 1);
    wire        ti_reach = (({1'b0, ti_num_r} + {8'h00, ti_end}) >= {1'b0, sleep_r});
    wire        rise_due = drift_unit & (rise_cnt_r >= rise_r) & (rise_r != `TCAT_RATE_OFF);
    wire        fall_due = drift_unit & (fall_cnt_r >= fall_r) & (fall_r != `TCAT_RATE_OFF);

    // Comparator pins pass two flip-flops before use.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            cmp_a_s_r <= 2'b00;
            cmp_b_s_r <= 2'b00;
        end else begin
            cmp_a_s_r <= {cmp_a_s_r[0], cmp_a_i};
            cmp_b_s_r <= {cmp_b_s_r[0], cmp_b_i};
        end
    end

    // Register slave answers one cycle after a request appears.
    always @* begin
        rd_nxt = 32'h00000000;
        case (avs_address_i)
            `TCAT_REG_CTRL: begin
                rd_nxt = {7'h00, fast_sel_r, fall_r, rise_r, sleep_r};
            end
            `TCAT_REG_CHAN_A: begin
                rd_nxt = {8'h00, tgt_r[0], 3'h0, hys_r[0], 3'h0, thr_r[0]};
            end
            `TCAT_REG_CHAN_B: begin
                rd_nxt = {8'h00, tgt_r[1], 3'h0, hys_r[1], 3'h0, thr_r[1]};
            end
            `TCAT_REG_MAXON: begin
                rd_nxt = {24'h000000, maxon_r};
            end
            `TCAT_REG_STATUS: begin
                rd_nxt = {28'h0000000, cal_r[1], cal_r[0], det_r[1], det_r[0]};
            end
            `TCAT_REG_LEVEL_A: begin
                rd_nxt = {ref_r[0], sig_r[0]};
            end
            `TCAT_REG_LEVEL_B: begin
                rd_nxt = {ref_r[1], sig_r[1]};
            end
            default: begin
                rd_nxt = 32'h00000000;
            end
        endcase
    end

    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o    <= 32'h00000000;
        end else begin
            avs_waitrequest_o <= ~((avs_read_i | avs_write_i) & avs_waitrequest_o);
            if (avs_read_i & avs_waitrequest_o) begin
                avs_readdata_o <= rd_nxt;
            end
        end
    end

    // Configuration registers.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            sleep_r    <= `TCAT_RST_SLEEP;
            rise_r     <= `TCAT_RST_RISE;
            fall_r     <= `TCAT_RST_FALL;
            fast_sel_r <= `TCAT_RST_FAST;
            maxon_r    <= `TCAT_RST_MAXON;
            for (j = 0; j < 2; j = j + 1) begin
                thr_r[j] <= `TCAT_RST_THR;
                hys_r[j] <= `TCAT_RST_HYS;
                tgt_r[j] <= `TCAT_RST_TGT_M1;
            end
        end else if (wr_en) begin
            case (avs_address_i)
                `TCAT_REG_CTRL: begin
                    sleep_r    <= avs_writedata_i[`TCAT_CTRL_SLEEP_LSB +: 8];
                    rise_r     <= avs_writedata_i[`TCAT_CTRL_RISE_LSB +: 8];
                    fall_r     <= avs_writedata_i[`TCAT_CTRL_FALL_LSB +: 8];
                    fast_sel_r <= avs_writedata_i[`TCAT_CTRL_FAST_BIT];
                end
                `TCAT_REG_CHAN_A: begin
                    thr_r[0] <= avs_writedata_i[`TCAT_CHAN_THR_LSB +: 5];
                    hys_r[0] <= avs_writedata_i[`TCAT_CHAN_HYS_LSB +: 5];
                    tgt_r[0] <= avs_writedata_i[`TCAT_CHAN_TGT_LSB +: 8];
                end
                `TCAT_REG_CHAN_B: begin
                    thr_r[1] <= avs_writedata_i[`TCAT_CHAN_THR_LSB +: 5];
                    hys_r[1] <= avs_writedata_i[`TCAT_CHAN_HYS_LSB +: 5];
                    tgt_r[1] <= avs_writedata_i[`TCAT_CHAN_TGT_LSB +: 8];
                end
                `TCAT_REG_MAXON: begin
                    maxon_r <= avs_writedata_i[7:0];
                end
                default: begin
                    sleep_r <= sleep_r;
                end
            endcase
        end
    end

    // Fast pacing holds while any confirm or release counter is mid-count.
    always @* begin
        fast_now = fast_sel_r & ((conf_r[0] != 8'h00) | (conf_r[1] != 8'h00) |
                                 (rel_r[0] != 3'h0) | (rel_r[1] != 3'h0));
    end

    // Burst sequencer and interval timer.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            state_r  <= ST_BURST_B;
            cyc_r    <= 32'h00000000;
            ti_num_r <= 8'h00;
            xdiv_r   <= 16'h0000;
            xcnt_r   <= 16'h0000;
            xfer_a_o <= 1'b0;
            xfer_b_o <= 1'b0;
            sig_r[0] <= 16'h0000;
            sig_r[1] <= 16'h0000;
        end else begin
            xfer_a_o <= 1'b0;
            xfer_b_o <= 1'b0;
            if (cyc_r == BASE_INTERVAL_CYC - 1) begin
                cyc_r <= 32'h00000000;
                if (ti_num_r != 8'hFF) begin
                    ti_num_r <= ti_num_r + 8'h01;
                end
            end else begin
                cyc_r <= cyc_r + 32'h00000001;
            end
            if ((state_r == ST_BURST_B) | (state_r == ST_BURST_A)) begin
                xdiv_r <= xfer_en ? 16'h0000 : xdiv_r + 16'h0001;
            end
            case (state_r)
                ST_BURST_B: begin
                    if (burst_end) begin
                        sig_r[1] <= xcnt_r;
                        xcnt_r   <= 16'h0000;
                        xdiv_r   <= 16'h0000;
                        state_r  <= ST_BURST_A;
                    end else if (xfer_en) begin
                        xfer_b_o <= 1'b1;
                        xcnt_r   <= xcnt_r + 16'h0001;
                    end
                end
                ST_BURST_A: begin
                    if (burst_end) begin
                        sig_r[0] <= xcnt_r;
                        xcnt_r   <= 16'h0000;
                        xdiv_r   <= 16'h0000;
                        state_r  <= ST_EVAL;
                    end else if (xfer_en) begin
                        xfer_a_o <= 1'b1;
                        xcnt_r   <= xcnt_r + 16'h0001;
                    end
                end
                ST_EVAL: begin
                    state_r <= ST_SLEEP;
                end
                ST_SLEEP: begin
                    if (~slept | fast_now | ti_reach) begin
                        state_r  <= ST_BURST_B;
                        cyc_r    <= 32'h00000000;
                        ti_num_r <= 8'h00;
                    end
                end
                default: begin
                    state_r <= ST_BURST_B;
                end
            endcase
        end
    end

    // Period prescaler and shared drift timers.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            pre_r      <= 8'h00;
            rise_cnt_r <= 8'h00;
            fall_cnt_r <= 8'h00;
        end else if (state_r == ST_EVAL) begin
            pre_r <= pre_r + 8'h01;
            if (drift_unit) begin
                rise_cnt_r <= (rise_cnt_r >= rise_r) ? 8'h00 : rise_cnt_r + 8'h01;
                fall_cnt_r <= (fall_cnt_r >= fall_r) ? 8'h00 : fall_cnt_r + 8'h01;
            end
        end
    end

    // Per-channel calibration, drift, integration and max-on.
    always @(posedge clk_sys_i) begin
        if (rst_i) begin
            detect_a_o <= 1'b0;
            detect_b_o <= 1'b0;
            for (i = 0; i < 2; i = i + 1) begin
                ref_r[i]  <= 16'h0000;
                conf_r[i] <= 8'h00;
                rel_r[i]  <= 3'h0;
                mo_r[i]   <= 8'h00;
                mo_pre_r[i] <= 8'h00;
                det_r[i]  <= 1'b0;
                cal_r[i]  <= 1'b1;
            end
        end else begin
            detect_a_o <= det_r[0];
            detect_b_o <= det_r[1];
            if (state_r == ST_EVAL) begin
                for (i = 0; i < 2; i = i + 1) begin
                    if (cal_r[i]) begin
                        ref_r[i]    <= sig_r[i];
                        conf_r[i]   <= 8'h00;
                        rel_r[i]    <= 3'h0;
                        mo_r[i]     <= 8'h00;
                        mo_pre_r[i] <= 8'h00;
                        det_r[i]    <= 1'b0;
                        cal_r[i]    <= 1'b0;
                    end else if (~det_r[i]) begin
                        mo_r[i]     <= 8'h00;
                        mo_pre_r[i] <= 8'h00;
                        if (dev_f(ref_r[i], sig_r[i]) >= {11'h000, thr_r[i]}) begin
                            if (conf_r[i] == tgt_r[i]) begin
                                det_r[i]  <= 1'b1;
                                conf_r[i] <= 8'h00;
                            end else begin
                                conf_r[i] <= conf_r[i] + 8'h01;
                            end
                        end else begin
                            conf_r[i] <= 8'h00;
                            if (rise_due & (sig_r[i] > ref_r[i])) begin
                                ref_r[i] <= ref_r[i] + 16'h0001;
                            end else if (fall_due & (sig_r[i] < ref_r[i])) begin
                                ref_r[i] <= ref_r[i] - 16'h0001;
                            end
                        end
                    end else begin
                        // Reference frozen while detecting.
                        if (({1'b0, dev_f(ref_r[i], sig_r[i])} + {12'h000, hys_r[i]}) <
                            {12'h000, thr_r[i]}) begin
                            if (rel_r[i] == rel_tgt_f(tgt_r[i])) begin
                                det_r[i] <= 1'b0;
                                rel_r[i] <= 3'h0;
                            end else begin
                                rel_r[i] <= rel_r[i] + 3'h1;
                            end
                        end else begin
                            rel_r[i] <= 3'h0;
                        end
                        // Each channel times its own max-on span from its detection start.
                        if (maxon_r != `TCAT_RATE_OFF) begin
                            if (slept ? (mo_pre_r[i][3:0] != 4'hF) : (mo_pre_r[i] != 8'hFF)) begin
                                mo_pre_r[i] <= mo_pre_r[i] + 8'h01;
                            end else if (mo_r[i] == maxon_r) begin
                                mo_pre_r[i] <= 8'h00;
                                cal_r[i]    <= 1'b1;
                                det_r[i]    <= 1'b0;
                                rel_r[i]    <= 3'h0;
                            end else begin
                                mo_pre_r[i] <= 8'h00;
                                mo_r[i]     <= mo_r[i] + 8'h01;
                            end
                        end
                    end
                end
            end
        end
    end

endmodule

//--- tcat_defines.vh
// Constants for the two-channel touch acquisition block.
// Assumes a 20 MHz system clock and word-addressed Avalon-MM registers.
`ifndef TCAT_DEFINES_VH
`define TCAT_DEFINES_VH

// System clock and charge-transfer rate.
`define TCAT_CLK_HZ          20000000
`define TCAT_XFER_HZ         500000
`define TCAT_XFER_DIV        (`TCAT_CLK_HZ / `TCAT_XFER_HZ)

// Basic timing interval, in microseconds and in clock cycles.
`define TCAT_BASE_INTERVAL_US 16000
`define TCAT_BASE_INTERVAL_CYC (`TCAT_BASE_INTERVAL_US * (`TCAT_CLK_HZ / 1000000))

// Register word offsets.
`define TCAT_REG_CTRL        3'h0
`define TCAT_REG_CHAN_A      3'h1
`define TCAT_REG_CHAN_B      3'h2
`define TCAT_REG_MAXON       3'h3
`define TCAT_REG_STATUS      3'h4
`define TCAT_REG_LEVEL_A     3'h5
`define TCAT_REG_LEVEL_B     3'h6

// Control register fields.
`define TCAT_CTRL_SLEEP_LSB  0
`define TCAT_CTRL_RISE_LSB   8
`define TCAT_CTRL_FALL_LSB   16
`define TCAT_CTRL_FAST_BIT   24

// Channel register fields.
`define TCAT_CHAN_THR_LSB    0
`define TCAT_CHAN_HYS_LSB    8
`define TCAT_CHAN_TGT_LSB    16

// Reset values.
`define TCAT_RST_SLEEP       8'h01
`define TCAT_RST_RISE        8'h64
`define TCAT_RST_FALL        8'h02
`define TCAT_RST_FAST        1'b1
`define TCAT_RST_THR         5'h06
`define TCAT_RST_HYS         5'h02
`define TCAT_RST_TGT_M1      8'h09
`define TCAT_RST_MAXON       8'h0E

// Special values.
`define TCAT_RATE_OFF        8'hFF
`define TCAT_REL_TGT_M1_MAX  8'h05

`endif

//--- tcat_sense_model.sv
// Model of the two sense electrodes with their sampling capacitors.
// Assumes one transfer pulse per charge step from the acquisition block.
`timescale 1ns/1ns
module tcat_sense_model (
    // Clock and reset.
    input  wire        clk_sys_i,
    input  wire        rst_i,
    // Transfer pulses and pulses needed to finish each measurement.
    input  wire        xfer_a_i,
    input  wire        xfer_b_i,
    input  wire [15:0] n_a_i,
    input  wire [15:0] n_b_i,
    // Comparator pins.
    output wire        cmp_a_o,
    output wire        cmp_b_o
);
    reg [15:0] cnt_a_r = 16'h0000;
    reg [15:0] cnt_b_r = 16'h0000;

    // Each channel counts its own pulses; the other channel's burst empties it.
    always @(posedge clk_sys_i) begin
        if (rst_i || xfer_b_i) begin
            cnt_a_r <= 16'h0000;
        end else if (xfer_a_i) begin
            cnt_a_r <= cnt_a_r + 16'h0001;
        end
        if (rst_i || xfer_a_i) begin
            cnt_b_r <= 16'h0000;
        end else if (xfer_b_i) begin
            cnt_b_r <= cnt_b_r + 16'h0001;
        end
    end

    // The measurement completes once enough charge has been moved.
    assign cmp_a_o = (cnt_a_r != 16'h0000) && (cnt_a_r >= n_a_i);
    assign cmp_b_o = (cnt_b_r != 16'h0000) && (cnt_b_r >= n_b_i);
endmodule

//--- tcat_acq_asserts.sv
// Checker for the two-channel touch acquisition block.
// Assumes it is bound to every instance of tcat_acq.
`timescale 1ns/1ns
module tcat_acq_chk (
    // Clock and reset.
    input wire        clk_sys_i,
    input wire        rst_i,
    // Register bus.
    input wire [2:0]  avs_address_i,
    input wire        avs_read_i,
    input wire        avs_write_i,
    input wire [31:0] avs_readdata_o,
    input wire        avs_waitrequest_o,
    // Pins.
    input wire        xfer_a_o,
    input wire        xfer_b_o,
    input wire        detect_a_o,
    input wire        detect_b_o
);
    xfer_excl_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !(xfer_a_o && xfer_b_o)) else $error("both channels pulse at once");
    xfer_pulse_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        xfer_a_o |=> !xfer_a_o) else $error("transfer pulse too long");
    xfer_space_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        xfer_b_o |=> (!xfer_b_o) [*8]) else $error("transfer pulses too close");
    reset_quiet_a: assert property (@(posedge clk_sys_i) rst_i |=>
        !xfer_a_o && !xfer_b_o && !detect_a_o && !detect_b_o)
        else $error("outputs active after reset");
    calib_quiet_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(rst_i) |-> (!detect_a_o && !detect_b_o) [*8])
        else $error("detect right after reset");
    wait_answer_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
        else $error("bus answer late");
    wait_one_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        !avs_waitrequest_o |=> avs_waitrequest_o) else $error("waitrequest low too long");
    wait_cause_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        $fell(avs_waitrequest_o) |-> $past(avs_read_i || avs_write_i))
        else $error("answer without request");
    rd_unmap_a: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        avs_read_i && avs_address_i == 3'h7 && !avs_waitrequest_o |-> avs_readdata_o == 32'h0)
        else $error("unmapped read not zero");
endmodule

bind tcat_acq tcat_acq_chk tcat_acq_chk_i (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .xfer_a_o(xfer_a_o), .xfer_b_o(xfer_b_o),
    .detect_a_o(detect_a_o), .detect_b_o(detect_b_o));

//--- tcat_tb.sv
// Self-checking bench for the two-channel touch acquisition block.
// Assumes the sense model answers the transfer pulses.
`timescale 1ns/1ns
module tb;
    localparam [31:0] BASE = 32'h000004B0;
    reg         clk_sys_i       = 1'b0;
    reg         rst_i           = 1'b1;
    reg  [2:0]  avs_address_i   = 3'h0;
    reg         avs_read_i      = 1'b0;
    reg         avs_write_i     = 1'b0;
    reg  [31:0] avs_writedata_i = 32'h0;
    reg  [15:0] n_a             = 16'h000C;
    reg  [15:0] n_b             = 16'h000C;
    reg         last_b          = 1'b0;
    reg  [31:0] rd;
    wire [31:0] avs_readdata_o;
    wire        avs_waitrequest_o;
    wire        cmp_a;
    wire        cmp_b;
    wire        xfer_a;
    wire        xfer_b;
    wire        det_a;
    wire        det_b;
    integer     n_errors = 0, check_count = 0, cyc = 0, k;
    integer     pair_n = 0, pair_t = 0, pair_dt = 0, a_cnt = 0, a0 = 0;

    tcat_acq #(.BASE_INTERVAL_CYC(BASE), .XFER_DIV(40), .MAX_XFER(16'h0040)) tcat_acq_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
        .avs_waitrequest_o(avs_waitrequest_o), .cmp_a_i(cmp_a), .cmp_b_i(cmp_b),
        .xfer_a_o(xfer_a), .xfer_b_o(xfer_b), .detect_a_o(det_a), .detect_b_o(det_b));
    tcat_sense_model tcat_sense_model_i (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .xfer_a_i(xfer_a), .xfer_b_i(xfer_b),
        .n_a_i(n_a), .n_b_i(n_b), .cmp_a_o(cmp_a), .cmp_b_o(cmp_b));

    always #25 clk_sys_i = ~clk_sys_i;

    // Marks the first B pulse of every burst pair and times the pair spacing.
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (xfer_a) begin
            last_b <= 1'b0;
            a_cnt <= a_cnt + 1;
        end
        if (xfer_b && !last_b) begin
            last_b <= 1'b1;
            if (pair_n == 0) begin
                a0 <= a_cnt;
            end
            pair_n <= pair_n + 1;
            pair_t <= cyc;
            pair_dt <= cyc - pair_t;
        end
    end

    task chk(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task bus(input wr, input [2:0] a, input [31:0] d);
        begin
            avs_address_i <= a;
            avs_read_i <= !wr;
            avs_write_i <= wr;
            avs_writedata_i <= d;
            @(posedge clk_sys_i);
            while (avs_waitrequest_o !== 1'b0) @(posedge clk_sys_i);
            rd = avs_readdata_o;
            avs_read_i <= 1'b0;
            avs_write_i <= 1'b0;
            @(posedge clk_sys_i);
        end
    endtask

    task pairs(input integer m);
        begin
            repeat (m) @(pair_n);
            @(posedge clk_sys_i);
        end
    endtask

    task end_sim;
        begin
            $display("checks %0d errors %0d", check_count, n_errors);
            if (n_errors == 0 && check_count > 0) begin
                $display("STATUS OK");
            end else begin
                $display("STATUS NOT OK");
            end
            $finish;
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        bus(1'b0, 3'h0, 32'h0);
        chk(rd, 32'h01026401);
        bus(1'b0, 3'h1, 32'h0);
        chk(rd, 32'h00090206);
        bus(1'b0, 3'h2, 32'h0);
        chk(rd, 32'h00090206);
        bus(1'b0, 3'h3, 32'h0);
        chk(rd, 32'h0000000E);
        bus(1'b1, 3'h7, 32'hFFFFFFFF);
        bus(1'b0, 3'h7, 32'h0);
        chk(rd, 32'h0);
        // Drift off, sleep one, target three, hysteresis kept below threshold.
        bus(1'b1, 3'h0, 32'h00FFFF01);
        bus(1'b1, 3'h2, 32'h00020206);
        bus(1'b1, 3'h3, 32'h0);
        bus(1'b0, 3'h0, 32'h0);
        chk(rd, 32'h00FFFF01);
        pairs(1);
        chk(a0, 32'h0);
        pairs(2);
        chk(pair_dt, BASE);
        bus(1'b0, 3'h6, 32'h0);
        chk(rd, 32'h000C000C);
        n_b <= 16'h0007;
        pairs(4);
        chk({31'h0, det_b}, 32'h0);
        n_b <= 16'h0006;
        pairs(2);
        chk({31'h0, det_b}, 32'h0);
        pairs(1);
        chk({31'h0, det_b}, 32'h1);
        chk({31'h0, det_a}, 32'h0);
        n_b <= 16'h0008;
        pairs(3);
        chk({31'h0, det_b}, 32'h1);
        n_b <= 16'h0009;
        pairs(2);
        chk({31'h0, det_b}, 32'h1);
        pairs(1);
        chk({31'h0, det_b}, 32'h0);
        bus(1'b1, 3'h0, 32'h01FFFF01);
        n_b <= 16'h0006;
        pairs(1);
        chk({31'h0, pair_dt < BASE}, 32'h1);
        pairs(2);
        chk({31'h0, det_b}, 32'h1);
        chk(pair_dt, BASE);
        k = 0;
        while (det_b === 1'b1 && k < 24) begin
            pairs(1);
            k = k + 1;
        end
        chk(k, 32'h00000010);
        pairs(2);
        chk({31'h0, det_b}, 32'h0);
        bus(1'b0, 3'h6, 32'h0);
        chk(rd, 32'h00060006);
        bus(1'b0, 3'h5, 32'h0);
        chk(rd, 32'h000C000C);
        bus(1'b1, 3'h0, 32'h00FFFF00);
        pairs(3);
        chk({31'h0, pair_dt < BASE && pair_dt >= 32'h000002D0}, 32'h1);
        // Rise rate zero steps every period; fall rate off leaves the reference alone.
        bus(1'b1, 3'h0, 32'h00FF0001);
        n_a <= 16'h000D;
        pairs(2);
        bus(1'b0, 3'h5, 32'h0);
        chk(rd, 32'h000D000D);
        n_a <= 16'h000B;
        pairs(2);
        bus(1'b0, 3'h5, 32'h0);
        chk(rd, 32'h000D000B);
        end_sim;
    end

    initial begin
        repeat (90000) @(posedge clk_sys_i);
        n_errors = n_errors + 1;
        end_sim;
    end
endmodule
